// [dma_status_pkg.sv]
// constants for the bus-master status and descriptor-pointer block
// assumes a word-wide register port, byte address = register index * 4
package dma_status_pkg;

  // ==========================================================
  // register indices (byte address is index times four)
  localparam logic [9:0] IDX_DMA_CONTROL = 10'h000;
  localparam logic [9:0] IDX_DMA_STATUS = 10'h002;
  localparam logic [9:0] IDX_DESC_PTR = 10'h004;
  localparam logic [9:0] IDX_TIMING = 10'h040;
  localparam logic [9:0] IDX_READY_TIMER = 10'h078;
  localparam logic [9:0] IDX_EVENT = 10'h080;
  localparam logic [9:0] IDX_EVENT_MASK = 10'h081;
  localparam int ADDR_W = 12;

  // ==========================================================
  // field positions
  localparam int CTL_GO_BIT = 0;
  localparam int CTL_DIR_BIT = 3;
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_ERROR_BIT = 1;
  localparam int ST_IRQ_BIT = 2;
  localparam int ST_TIMEOUT_BIT = 3;
  localparam int TIM_DEV0_BUF_BIT = 2;
  localparam int TIM_DEV1_BUF_BIT = 6;
  localparam int TIM_DECODE_BIT = 15;
  localparam int RDY_EN_BIT = 31;
  localparam int RDY_LIMIT_W = 16;
  localparam int EV_DONE_BIT = 3;

  // ==========================================================
  // reset values and fixed counts
  localparam logic [15:0] TIMING_RESET = 16'h0000;
  localparam logic [29:0] DESC_PTR_RESET = 30'h00000000;
  localparam logic [15:0] RDY_LIMIT_RESET = 16'h00ff;
  localparam logic [3:0] EVENT_MASK_RESET = 4'h0;
  localparam logic [29:0] DESC_STRIDE_WORDS = 30'h00000002;

  // engine state
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } engine_state_t;

endpackage : dma_status_pkg

// [dma_status_top.sv]
// status, descriptor pointer and timing-control block of a bus-master channel
// assumes the data mover reports region completion and buffer faults, and
// that the device interrupt and ready lines arrive asynchronously on pins
// Operation
// - ready-wait timer expiry sets timeout flag, W1C
// - device interrupt rising edge sets latch, W1C
// - transfer completion also sets interrupt latch
// - latch holds after device line falls
// - buffer overflow/underflow while engine running sets error flag, W1C
// - writing go bit sets engine active
// - final region finished clears engine active
// - writing go bit zero aborts, clears active
// - 32-bit pointer, bits 31-2 read/write
// - pointer low two bits read zero
// - pointer advances unless end of table
// - 16-bit timing register, decode and buffering
// - buffering enabled routes PIO through FIFO
// - start on 0-to-1, zero ends for good
// - writing zero leaves W1C flags unchanged
// - decode disabled blocks PIO cable activity
`timescale 1ns/1ps
module dma_status_top (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // register port
  input wire logic [dma_status_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // device pins, asynchronous
  input wire logic DEV_INTRQ,
  input wire logic DEV_IORDY,
  // data mover status
  input wire logic REGION_DONE,
  input wire logic REGION_EOT,
  input wire logic FIFO_OVERFLOW,
  input wire logic FIFO_UNDERFLOW,
  input wire logic READY_WAIT,
  // pio request path
  input wire logic PIO_REQ,
  input wire logic PIO_DEV_SEL,
  output logic PIO_CABLE_REQ,
  output logic PIO_VIA_FIFO,
  // engine control
  output logic DMA_START,
  output logic DMA_ABORT,
  output logic DMA_ACTIVE,
  output logic DMA_TO_MEMORY,
  output logic [31:0] DESC_ADDR,
  // interrupt
  output logic IRQ
);
  import dma_status_pkg::*;

  // ==========================================================
  // address decode
  logic [9:0] reg_idx;
  logic addr_ok;
  logic wr_ctl, wr_st, wr_ptr, wr_tim, wr_rdy, wr_msk;
  logic rd_ev;

  // one comparator shape for every register select
  function automatic logic hit(input logic [9:0] idx, input logic [9:0] want);
    hit = (idx == want);
  endfunction : hit

  // misaligned byte addresses select nothing, so stray writes are dropped
  assign reg_idx = REG_ADDR[ADDR_W-1:2];
  assign addr_ok = (REG_ADDR[1:0] == 2'h0);
  assign wr_ctl = REG_WR & addr_ok & hit(reg_idx, IDX_DMA_CONTROL);
  assign wr_st = REG_WR & addr_ok & hit(reg_idx, IDX_DMA_STATUS);
  assign wr_ptr = REG_WR & addr_ok & hit(reg_idx, IDX_DESC_PTR);
  assign wr_tim = REG_WR & addr_ok & hit(reg_idx, IDX_TIMING);
  assign wr_rdy = REG_WR & addr_ok & hit(reg_idx, IDX_READY_TIMER);
  assign wr_msk = REG_WR & addr_ok & hit(reg_idx, IDX_EVENT_MASK);
  assign rd_ev = REG_RD & addr_ok & hit(reg_idx, IDX_EVENT);

  // ==========================================================
  // pin synchronisers: three stages, change taken when last two agree
  logic [2:0] intrq_s_q, iordy_s_q;
  logic intrq_q, iordy_q, intrq_prev_q;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      // interrupt resets to its idle low, ready to its pulled-up high
      intrq_s_q <= 3'h0;
      iordy_s_q <= 3'h7;
    end else begin
      intrq_s_q <= {intrq_s_q[1:0], DEV_INTRQ};
      iordy_s_q <= {iordy_s_q[1:0], DEV_IORDY};
    end
  end

  // filtered levels, stage 0 is never looked at
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      intrq_q <= 1'b0;
      iordy_q <= 1'b1;
      // matches the idle line, so leaving reset gives no false edge
      intrq_prev_q <= 1'b0;
    end else begin
      if (intrq_s_q[1] == intrq_s_q[2]) intrq_q <= intrq_s_q[2];
      if (iordy_s_q[1] == iordy_s_q[2]) iordy_q <= iordy_s_q[2];
      intrq_prev_q <= intrq_q;
    end
  end

  logic intrq_rise;
  // one-cycle pulse taken from the filtered level only
  assign intrq_rise = intrq_q & ~intrq_prev_q;

  // ==========================================================
  // control register and engine sequencing
  logic go_q, dir_q;
  engine_state_t state_q, state_d;
  logic go_rise, go_fall, last_done;

  // the start edge is judged against the stored bit, not the write alone
  assign go_rise = wr_ctl & REG_WDATA[CTL_GO_BIT] & ~go_q;
  assign go_fall = wr_ctl & ~REG_WDATA[CTL_GO_BIT] & go_q;
  // completion only counts while a transfer is really running
  assign last_done = (state_q == ST_RUN) & REGION_DONE & REGION_EOT;

  // go bit stays set after completion; only the 0-to-1 change starts
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      go_q <= 1'b0;
      dir_q <= 1'b0;
    end else if (wr_ctl) begin
      go_q <= REG_WDATA[CTL_GO_BIT];
      // direction is frozen while a transfer runs
      if (state_q != ST_RUN) dir_q <= REG_WDATA[CTL_DIR_BIT];
    end
  end

  // engine state: a stop always lands in idle, no resume possible
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (go_rise) state_d = ST_RUN;
      end
      ST_RUN: begin
        if (go_fall) state_d = ST_IDLE;
        else if (last_done) state_d = ST_DONE;
      end
      ST_DONE: begin
        if (go_fall) state_d = ST_IDLE;
        else if (go_rise) state_d = ST_RUN;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // engine state register
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) state_q <= ST_IDLE;
    else state_q <= state_d;
  end

  // ==========================================================
  // descriptor table pointer
  // the two low bits are never stored, so they cannot read back set
  logic [29:0] ptr_q;

  // software load wins over the hardware step; loading while running
  // is a software fault in any case
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ptr_q <= DESC_PTR_RESET;
    end else if (wr_ptr) begin
      ptr_q <= REG_WDATA[31:2];
    end else if ((state_q == ST_RUN) && REGION_DONE && !REGION_EOT) begin
      ptr_q <= ptr_q + DESC_STRIDE_WORDS;
    end
  end

  // ==========================================================
  // timing control and ready-wait timer configuration
  logic [15:0] tim_q;
  logic rdy_en_q;
  logic [RDY_LIMIT_W-1:0] rdy_limit_q;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tim_q <= TIMING_RESET;
    end else if (wr_tim) begin
      // only defined bits store, the rest of the 16 read zero
      tim_q <= 16'h0000;
      tim_q[TIM_DECODE_BIT] <= REG_WDATA[TIM_DECODE_BIT];
      tim_q[TIM_DEV1_BUF_BIT] <= REG_WDATA[TIM_DEV1_BUF_BIT];
      tim_q[TIM_DEV0_BUF_BIT] <= REG_WDATA[TIM_DEV0_BUF_BIT];
    end
  end

  // enable and limit are written together as one word
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdy_en_q <= 1'b0;
      rdy_limit_q <= RDY_LIMIT_RESET;
    end else if (wr_rdy) begin
      rdy_en_q <= REG_WDATA[RDY_EN_BIT];
      rdy_limit_q <= REG_WDATA[RDY_LIMIT_W-1:0];
    end
  end

  // ==========================================================
  // ready-wait timer: counts while a strobe waits on a low ready line
  logic [RDY_LIMIT_W-1:0] rdy_cnt_q;
  logic rdy_fired_q;
  logic rdy_expire;

  assign rdy_expire = rdy_en_q & READY_WAIT & ~iordy_q & ~rdy_fired_q &
                      (rdy_cnt_q == rdy_limit_q);

  // fires once per wait so a stuck device raises one event
  // limitation: a wait that outlasts the limit gives no second event
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdy_cnt_q <= '0;
      rdy_fired_q <= 1'b0;
    end else if (!(rdy_en_q && READY_WAIT && !iordy_q)) begin
      rdy_cnt_q <= '0;
      rdy_fired_q <= 1'b0;
    end else if (rdy_expire) begin
      rdy_fired_q <= 1'b1;
    end else if (!rdy_fired_q) begin
      rdy_cnt_q <= rdy_cnt_q + 1'b1;
    end
  end

  // ==========================================================
  // status flags; hardware set beats a same-cycle software clear
  logic timeout_q, irq_latch_q, buf_err_q;
  logic clr_timeout, clr_irq, clr_err;
  logic set_irq, set_err;

  assign clr_timeout = wr_st & REG_WDATA[ST_TIMEOUT_BIT];
  assign clr_irq = wr_st & REG_WDATA[ST_IRQ_BIT];
  assign clr_err = wr_st & REG_WDATA[ST_ERROR_BIT];
  assign set_irq = intrq_rise | last_done;
  assign set_err = (state_q == ST_RUN) & (FIFO_OVERFLOW | FIFO_UNDERFLOW);

  // latch ignores the falling line: only a 1 write clears it
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      timeout_q <= 1'b0;
      irq_latch_q <= 1'b0;
      buf_err_q <= 1'b0;
    end else begin
      timeout_q <= (timeout_q & ~clr_timeout) | rdy_expire;
      irq_latch_q <= (irq_latch_q & ~clr_irq) | set_irq;
      buf_err_q <= (buf_err_q & ~clr_err) | set_err;
    end
  end

  // active bit mirrors the engine state, there is nothing to clear
  logic [15:0] status_word;
  always_comb begin
    status_word = 16'h0000;
    status_word[ST_TIMEOUT_BIT] = timeout_q;
    status_word[ST_IRQ_BIT] = irq_latch_q;
    status_word[ST_ERROR_BIT] = buf_err_q;
    status_word[ST_ACTIVE_BIT] = (state_q == ST_RUN);
  end

  // ==========================================================
  // interrupt events: sticky, cleared by reading the event register
  logic [3:0] ev_q, mask_q, ev_set;

  assign ev_set = {last_done, intrq_rise, set_err, rdy_expire};

  // a read and a new event in one cycle keep the new event

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) ev_q <= 4'h0;
    else ev_q <= (rd_ev ? 4'h0 : ev_q) | ev_set;
  end

  // mask only gates the output, events still collect underneath
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) mask_q <= EVENT_MASK_RESET;
    else if (wr_msk) mask_q <= REG_WDATA[3:0];
  end

  // ==========================================================
  // read data, valid only the cycle after the strobe
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (addr_ok) begin
      case (reg_idx)
        IDX_DMA_CONTROL: begin
          rd_mux[CTL_GO_BIT] = go_q;
          rd_mux[CTL_DIR_BIT] = dir_q;
        end
        IDX_DMA_STATUS: rd_mux[15:0] = status_word;
        IDX_DESC_PTR: rd_mux = {ptr_q, 2'b00};
        IDX_TIMING: rd_mux[15:0] = tim_q;
        IDX_READY_TIMER: begin
          rd_mux[RDY_EN_BIT] = rdy_en_q;
          rd_mux[RDY_LIMIT_W-1:0] = rdy_limit_q;
        end
        IDX_EVENT: rd_mux[3:0] = ev_q;
        IDX_EVENT_MASK: rd_mux[3:0] = mask_q;
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  // idle cycles return zero so a stray sample is harmless
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) REG_RDATA <= 32'h00000000;
    else if (REG_RD) REG_RDATA <= rd_mux;
    else REG_RDATA <= 32'h00000000;
  end

  // ==========================================================
  // outputs to the data mover and pio path
  // start and abort are registered pulses, one cycle each
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      DMA_START <= 1'b0;
      DMA_ABORT <= 1'b0;
    end else begin
      DMA_START <= go_rise & (state_q != ST_RUN);
      DMA_ABORT <= go_fall & (state_q == ST_RUN);
    end
  end

  assign DMA_ACTIVE = (state_q == ST_RUN);
  assign DMA_TO_MEMORY = dir_q;
  assign DESC_ADDR = {ptr_q, 2'b00};
  // no cable cycle at all while decode is off
  assign PIO_CABLE_REQ = PIO_REQ & tim_q[TIM_DECODE_BIT];
  // pio data borrows the dma fifo for the selected device
  assign PIO_VIA_FIFO = PIO_DEV_SEL ? tim_q[TIM_DEV1_BUF_BIT]
                                    : tim_q[TIM_DEV0_BUF_BIT];
  // level interrupt, drops once the events are read or masked off
  assign IRQ = |(ev_q & mask_q);

endmodule : dma_status_top

// [dma_status_assertions.sv]
// concurrent checks on the ports of the bus-master status block
// assumes one clock domain and the register map of dma_status_pkg
`timescale 1ns/1ps
module dma_status_assertions (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // register port
  input wire logic [dma_status_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  // mover and pio
  input wire logic REGION_DONE,
  input wire logic REGION_EOT,
  input wire logic PIO_REQ,
  input wire logic PIO_CABLE_REQ,
  // engine
  input wire logic DMA_START,
  input wire logic DMA_ACTIVE,
  input wire logic [31:0] DESC_ADDR
);
  import dma_status_pkg::*;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // ==========================================================
  // engine sequences
  sequence s_final;
    DMA_ACTIVE && REGION_DONE && REGION_EOT && !REG_WR;
  endsequence
  sequence s_middle;
    DMA_ACTIVE && REGION_DONE && !REGION_EOT && !REG_WR;
  endsequence
  sequence s_abort;
    REG_WR && REG_ADDR == 12'h000 && !REG_WDATA[0] && DMA_ACTIVE;
  endsequence
  // decode enable as software last wrote it, for the cable gate
  logic decode_q;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) decode_q <= 1'b0;
    else if (REG_WR && REG_ADDR == 12'h100) decode_q <= REG_WDATA[15];
  end
  // ==========================================================
  // properties
  a_start_sets_active: assert property (DMA_START |-> DMA_ACTIVE)
    else $error("start pulse without active");
  a_start_pulse: assert property (DMA_START |=> !DMA_START)
    else $error("start pulse longer than one cycle");
  a_final_clears: assert property (s_final |=> !DMA_ACTIVE)
    else $error("active survived final region");
  a_abort_clears: assert property (s_abort |=> !DMA_ACTIVE)
    else $error("active survived abort");
  a_ptr_advance: assert property (s_middle |=> DESC_ADDR == $past(DESC_ADDR) + 32'h8)
    else $error("pointer did not advance by one descriptor");
  a_ptr_aligned: assert property (DESC_ADDR[1:0] == 2'b00)
    else $error("pointer low bits not zero");
  a_ptr_write: assert property (REG_WR && REG_ADDR == 12'h010 && !DMA_ACTIVE
    && !REGION_DONE |=> DESC_ADDR == {$past(REG_WDATA[31:2]), 2'b00})
    else $error("pointer write not taken");
  a_ptr_readback: assert property ($past(REG_RD) && $past(REG_ADDR) == 12'h010
    |-> REG_RDATA == $past(DESC_ADDR))
    else $error("pointer read mismatch");
  a_status_reserved: assert property ($past(REG_RD) && $past(REG_ADDR) == 12'h008
    |-> REG_RDATA[31:4] == 28'h0000000)
    else $error("reserved status bits set");
  a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h00000000)
    else $error("read data outside read cycle");
  a_decode_gate: assert property (PIO_CABLE_REQ |-> PIO_REQ)
    else $error("cable request without pio request");
  a_decode_follows: assert property (PIO_CABLE_REQ == (PIO_REQ && decode_q))
    else $error("cable request does not follow decode enable");
endmodule : dma_status_assertions

bind dma_status_top dma_status_assertions u_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .REGION_DONE(REGION_DONE), .REGION_EOT(REGION_EOT),
  .PIO_REQ(PIO_REQ), .PIO_CABLE_REQ(PIO_CABLE_REQ), .DMA_START(DMA_START),
  .DMA_ACTIVE(DMA_ACTIVE), .DESC_ADDR(DESC_ADDR));

// [ata_device_model.sv]
// behavioural attached drive: interrupt line and ready line
// assumes the bench asks for an interrupt pulse or a ready stall
`timescale 1ns/1ps
module ata_device_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bench requests
  input wire logic irq_req,
  input wire logic stall_req,
  // drive pins
  output logic intrq,
  output logic iordy
);
  logic [2:0] irq_cnt_q;
  // interrupt held a few cycles, then dropped so the latch is seen alone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_cnt_q <= 3'h0;
    end else if (irq_req) begin
      irq_cnt_q <= 3'h6;
    end else if (irq_cnt_q != 3'h0) begin
      irq_cnt_q <= irq_cnt_q - 3'h1;
    end
  end
  assign intrq = (irq_cnt_q != 3'h0);
  // ready is pulled up on the cable, low only while stalling
  assign iordy = !stall_req;
endmodule : ata_device_model

// [dma_status_top_tb.sv]
// self-checking bench for the bus-master status block
// assumes the register map of dma_status_pkg and the drive model
`timescale 1ns/1ps
module dma_status_top_tb;
  import dma_status_pkg::*;
  logic SYS_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [ADDR_W-1:0] REG_ADDR = '0;
  logic [31:0] REG_WDATA = '0;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [31:0] REG_RDATA;
  logic [3:0] mov = 4'h0;
  logic READY_WAIT = 1'b0;
  logic PIO_REQ = 1'b0;
  logic PIO_DEV_SEL = 1'b0;
  logic irq_req = 1'b0;
  logic stall_req = 1'b0;
  logic intrq, iordy, cable, via, start, abort, active, to_mem, irq;
  logic [31:0] desc;
  logic rd_pend = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h0000c3f0;
  logic [15:0] tbl[4] = '{16'h0000, 16'h8004, 16'h8040, 16'h0044};
  int n_errors = 0;
  int n_tests = 0;
  always #5 SYS_CLK = ~SYS_CLK;
  // ==========================================================
  // design and drive model
  dma_status_top dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .DEV_INTRQ(intrq), .DEV_IORDY(iordy), .REGION_DONE(mov[0]), .REGION_EOT(mov[1]),
    .FIFO_OVERFLOW(mov[2]), .FIFO_UNDERFLOW(mov[3]), .READY_WAIT(READY_WAIT),
    .PIO_REQ(PIO_REQ), .PIO_DEV_SEL(PIO_DEV_SEL), .PIO_CABLE_REQ(cable),
    .PIO_VIA_FIFO(via), .DMA_START(start), .DMA_ABORT(abort), .DMA_ACTIVE(active),
    .DMA_TO_MEMORY(to_mem), .DESC_ADDR(desc), .IRQ(irq));
  ata_device_model u_dev (.clk(SYS_CLK), .rst_n(RST_N), .irq_req(irq_req),
    .stall_req(stall_req), .intrq(intrq), .iordy(iordy));
  // ==========================================================
  // tasks
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xorshift
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      n_errors++;
      $display("FAIL t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask : tick
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask : wr
  // expectation queued before the strobe so the monitor never runs dry
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge SYS_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
  endtask : rd
  task automatic pulse(input logic [3:0] m);
    @(posedge SYS_CLK);
    mov <= m;
    @(posedge SYS_CLK);
    mov <= 4'h0;
  endtask : pulse
  task automatic tally_and_finish();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  // read data stands only in the cycle after the strobe
  always @(posedge SYS_CLK) begin
    if (rd_pend) check(REG_RDATA, exp_q.pop_front());
    rd_pend <= REG_RD;
  end
  // hang guard, far beyond the few hundred cycles of the sequence
  initial begin
    #300000;
    n_errors++;
    tally_and_finish();
  end
  // ==========================================================
  // scenarios
  initial begin
    logic [31:0] v;
    repeat (12) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    rd(12'h008, 32'h0);
    rd(12'h010, 32'h0);
    rd(12'h100, 32'h0);
    rd(12'h1e0, 32'h000000ff);
    rd(12'h00c, 32'h0);
    rd(12'h011, 32'h0);
    v = xorshift();
    wr(12'h010, v);
    rd(12'h010, {v[31:2], 2'b00});
    wr(12'h010, ~v);
    rd(12'h010, {~v[31:2], 2'b00});
    // drive interrupt latched after the line falls
    wr(12'h204, 32'h4);
    @(posedge SYS_CLK) irq_req <= 1'b1;
    @(posedge SYS_CLK) irq_req <= 1'b0;
    tick(20);
    check(irq, 1'b1);
    rd(12'h008, 32'h4);
    wr(12'h008, 32'h0);
    rd(12'h008, 32'h4);
    wr(12'h008, 32'h4);
    rd(12'h008, 32'h0);
    rd(12'h200, 32'h4);
    tick(2);
    check(irq, 1'b0);
    // two middle regions then the final one; start pulse seen while it stands
    wr(12'h010, 32'h100);
    wr(12'h000, 32'h1);
    #1;
    check(start, 1'b1);
    tick(1);
    check(start, 1'b0);
    check(active, 1'b1);
    check(to_mem, 1'b0);
    rd(12'h008, 32'h1);
    // a second 1 while running must not restart
    wr(12'h000, 32'h1);
    #1;
    check(start, 1'b0);
    pulse(4'h1);
    pulse(4'h1);
    rd(12'h010, 32'h110);
    pulse(4'h3);
    tick(1);
    check(active, 1'b0);
    check(irq, 1'b0);
    rd(12'h008, 32'h4);
    rd(12'h200, 32'h8);
    wr(12'h000, 32'h0);
    #1;
    check(abort, 1'b0);
    wr(12'h008, 32'h4);
    // buffer faults in flight, then abort; direction frozen while running
    wr(12'h000, 32'h9);
    pulse(4'h4);
    rd(12'h008, 32'h3);
    wr(12'h008, 32'h2);
    pulse(4'h8);
    rd(12'h008, 32'h3);
    wr(12'h008, 32'h2);
    wr(12'h000, 32'h0);
    #1;
    check(abort, 1'b1);
    check(to_mem, 1'b1);
    rd(12'h000, 32'h8);
    rd(12'h008, 32'h0);
    pulse(4'h1);
    rd(12'h010, 32'h110);
    // ready stall longer than the timer limit
    wr(12'h1e0, 32'h80000004);
    wr(12'h204, 32'h1);
    @(posedge SYS_CLK);
    stall_req <= 1'b1;
    READY_WAIT <= 1'b1;
    tick(20);
    check(irq, 1'b1);
    @(posedge SYS_CLK);
    stall_req <= 1'b0;
    READY_WAIT <= 1'b0;
    rd(12'h008, 32'h8);
    rd(12'h200, 32'h3);
    tick(2);
    check(irq, 1'b0);
    wr(12'h008, 32'h8);
    rd(12'h008, 32'h0);
    // decode and per-drive buffering for four of the eight enable mixes
    PIO_REQ <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(12'h100, {16'h0000, tbl[i]});
      rd(12'h100, {16'h0000, tbl[i]});
      for (int s = 0; s < 2; s++) begin
        @(posedge SYS_CLK) PIO_DEV_SEL <= s[0];
        tick(2);
        check(cable, tbl[i][15]);
        check(via, s ? tbl[i][6] : tbl[i][2]);
      end
    end
    tick(4);
    tally_and_finish();
  end
endmodule : dma_status_top_tb
